// ---- hw/lpr_regs.sv ----
/*
  lpr_regs: AHB-Lite register bank with indirect phy register access,
  global interrupt summary and port control, and general purpose timer.
  Assumes single-word transfers and a phy interface on the same clock that
  takes one request per valid/ready handshake and returns read data as a
  one-cycle pulse. Module interrupt sources arrive as levels on hclk.
*/
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Overview of operation
// - host sets read bit with address; device sends read, clears bit when sent
// - returned phy data and address are stored; read-received flag raised
// - host sets write bit with address, data; device sends write, clears bit
// - after self-id ends, device reads phy register zero by itself
// - four read-only bits show which module raises an interrupt
// - summary bits follow module status, need no acknowledge
// - module enable bits 8..11 gate each module onto external interrupt
// - active-low interrupt stays asserted while any enabled status is set
// - direction bit one: port one transmitter, inputs; port two opposite
// - per-port output enable drives pins; zero means high impedance
// - run bit starts and stops the timer unless bus-reset start mode
// - preload copied to hidden counter, decremented each 80.14 ns unit
// - counter at zero pulses timer_expired; no interrupt raised, timer_int_enable unused
// - continuous reloads and restarts; otherwise one cycle then stop
// - bus-reset mode starts on each bus reset, ignores run bit
// - further bus reset reloads timer; no interrupt before expiry
// - continuous timer keeps expiring regardless of flag acknowledge
module lpr_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // phy request and return channel
  output logic phy_req_valid,
  input wire logic phy_req_ready,
  output logic phy_req_write,
  output logic [3:0] phy_req_addr,
  output logic [7:0] phy_req_data,
  input wire logic phy_rx_valid,
  input wire logic [3:0] phy_rx_addr,
  input wire logic [7:0] phy_rx_data,
  // bus events from the link core
  input wire logic self_id_done,
  input wire logic bus_reset_start,
  // link/phy interrupt status register lives in the link core
  input wire logic linkphy_pending,
  input wire logic iso_rx_pending,
  input wire logic iso_tx_pending,
  input wire logic async_pending,
  input wire logic timer_int_enable,
  output logic phy_read_received_flag,
  output logic timer_expired,
  output logic host_int_n,
  output logic av_port_direction,
  output logic av_port_one_oe,
  output logic av_port_two_oe,
  output logic av_port_one_is_input,
  output logic av_port_two_is_input
);
  logic rd_req_q;
  logic wr_req_q;
  logic [3:0] tgt_addr_q;
  logic [7:0] wval_q;
  logic [3:0] ret_addr_q;
  logic [7:0] ret_val_q;
  logic auto_rd_q;
  logic [3:0] mod_en_q;
  logic dir_q;
  logic oe1_q;
  logic oe2_q;
  logic [31:0] tmr_q;
  logic [31:0] rdata_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [3:0] summary;
  logic wr_fire;
  logic req_fire;
  logic tmr_active;
  lpr_pkg::lpr_phy_state_t state_q;

  function automatic logic sel_reg(input logic [11:0] a,
                                   input logic [11:0] r);
    sel_reg = (a == r);
  endfunction

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_fire = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr_q <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      if (sel_reg(haddr, lpr_pkg::ADDR_PHY_ACCESS)) begin
        rdata_q <= {rd_req_q, wr_req_q, 2'b00, tgt_addr_q, wval_q,
                    4'h0, ret_addr_q, ret_val_q};
      end else if (sel_reg(haddr, lpr_pkg::ADDR_GLOBAL_CTRL)) begin
        rdata_q <= {13'h0000, oe2_q, oe1_q, dir_q, 4'h0, mod_en_q,
                    4'h0, summary};
      end else if (sel_reg(haddr, lpr_pkg::ADDR_TIMER)) begin
        rdata_q <= tmr_q;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end
  assign hrdata = rdata_q;

  // ==========================================================
  // phy register access
  assign req_fire = phy_req_valid && phy_req_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_addr_q <= 4'h0;
      wval_q <= 8'h00;
    end else if (wr_fire && sel_reg(wr_addr_q, lpr_pkg::ADDR_PHY_ACCESS))
    begin
      tgt_addr_q <= hwdata[lpr_pkg::PA_ADDR_LSB +: 4];
      wval_q <= hwdata[lpr_pkg::PA_WDATA_LSB +: 8];
    end
  end

  // request bits clear once sent; a host set in the send cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
    end else if (wr_fire && sel_reg(wr_addr_q, lpr_pkg::ADDR_PHY_ACCESS))
    begin
      rd_req_q <= hwdata[lpr_pkg::PA_RD_BIT];
      wr_req_q <= hwdata[lpr_pkg::PA_WR_BIT];
    end else if (req_fire && state_q == lpr_pkg::LPR_IDLE && !auto_rd_q)
    begin
      if (phy_req_write) begin
        wr_req_q <= 1'b0;
      end else begin
        rd_req_q <= 1'b0;
      end
    end
  end

  // automatic read of phy register zero after self-id
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_rd_q <= 1'b0;
    end else if (self_id_done) begin
      auto_rd_q <= 1'b1;
    end else if (req_fire && state_q == lpr_pkg::LPR_IDLE) begin
      auto_rd_q <= 1'b0;
    end
  end

  // the auto read takes priority; host commands wait behind it
  always_comb begin
    phy_req_valid = 1'b0;
    phy_req_write = 1'b0;
    phy_req_addr = tgt_addr_q;
    phy_req_data = wval_q;
    if (state_q == lpr_pkg::LPR_IDLE) begin
      if (auto_rd_q) begin
        phy_req_valid = 1'b1;
        phy_req_addr = 4'(lpr_pkg::PHY_ZERO_ADDR);
      end else if (wr_req_q) begin
        phy_req_valid = 1'b1;
        phy_req_write = 1'b1;
      end else if (rd_req_q) begin
        phy_req_valid = 1'b1;
      end
    end
  end

  // one cycle of guard so a cleared request bit is not re-sent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= lpr_pkg::LPR_IDLE;
    end else begin
      case (state_q)
        lpr_pkg::LPR_IDLE: begin
          if (req_fire) begin
            state_q <= lpr_pkg::LPR_WAIT_ACK;
          end
        end
        default: begin
          state_q <= lpr_pkg::LPR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ret_addr_q <= 4'h0;
      ret_val_q <= 8'h00;
      phy_read_received_flag <= 1'b0;
    end else begin
      phy_read_received_flag <= phy_rx_valid;
      if (phy_rx_valid) begin
        ret_addr_q <= phy_rx_addr;
        ret_val_q <= phy_rx_data;
      end
    end
  end

  // ==========================================================
  // global interrupt summary and av port control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_en_q <= 4'h0;
      dir_q <= lpr_pkg::RST_GLOBAL_CTRL[lpr_pkg::GC_DIR_BIT];
      oe1_q <= 1'b0;
      oe2_q <= 1'b0;
    end else if (wr_fire && sel_reg(wr_addr_q, lpr_pkg::ADDR_GLOBAL_CTRL))
    begin
      mod_en_q <= hwdata[lpr_pkg::GC_EN_LSB +: 4];
      dir_q <= hwdata[lpr_pkg::GC_DIR_BIT];
      oe1_q <= hwdata[lpr_pkg::GC_OE1_BIT];
      oe2_q <= hwdata[lpr_pkg::GC_OE2_BIT];
    end
  end

  // summary is a live view, so it clears with the module status
  assign summary = {async_pending, iso_tx_pending, iso_rx_pending,
                    linkphy_pending};
  assign host_int_n = !(|(summary & mod_en_q));
  assign av_port_direction = dir_q;
  assign av_port_one_is_input = dir_q;
  assign av_port_two_is_input = !dir_q;
  assign av_port_one_oe = oe1_q;
  assign av_port_two_oe = oe2_q;

  // ==========================================================
  // general purpose timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_q <= lpr_pkg::RST_TIMER;
    end else if (wr_fire && sel_reg(wr_addr_q, lpr_pkg::ADDR_TIMER)) begin
      tmr_q <= {hwdata[31:29], 5'h00, hwdata[23:0]};
    end
  end

  lpr_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .timer_run(tmr_q[lpr_pkg::TM_RUN_BIT]),
    .timer_continuous(tmr_q[lpr_pkg::TM_CONT_BIT]),
    .timer_bus_reset_start(tmr_q[lpr_pkg::TM_BRE_BIT]),
    .preload(tmr_q[lpr_pkg::TM_PRELOAD_W-1:0]),
    .bus_reset_start(bus_reset_start),
    .expired(timer_expired),
    .active(tmr_active)
  );

  // ==========================================================
  // checks
  property p_rd_sent;
    @(posedge hclk) disable iff (!hresetn)
    req_fire && !phy_req_write && !auto_rd_q && !wr_fire |=> !rd_req_q;
  endproperty
  a_rd_sent: assert property (p_rd_sent)
    else $error("read bit not cleared after send");
  property p_wr_sent;
    @(posedge hclk) disable iff (!hresetn)
    req_fire && phy_req_write && !wr_fire |=> !wr_req_q;
  endproperty
  a_wr_sent: assert property (p_wr_sent)
    else $error("write bit not cleared after send");
  property p_rx_store;
    @(posedge hclk) disable iff (!hresetn)
    phy_rx_valid |=> ret_val_q == $past(phy_rx_data) &&
      ret_addr_q == $past(phy_rx_addr) && phy_read_received_flag;
  endproperty
  a_rx_store: assert property (p_rx_store)
    else $error("returned phy data not captured");
  property p_auto_read;
    @(posedge hclk) disable iff (!hresetn)
    self_id_done |=> state_q == lpr_pkg::LPR_WAIT_ACK ||
      (phy_req_valid && !phy_req_write && phy_req_addr == 4'h0);
  endproperty
  a_auto_read: assert property (p_auto_read)
    else $error("no auto read of phy register zero");
  property p_int_line;
    @(posedge hclk) disable iff (!hresetn)
    host_int_n == !(|(summary & mod_en_q));
  endproperty
  a_int_line: assert property (p_int_line)
    else $error("interrupt line disagrees with enabled summary");
  property p_mask;
    @(posedge hclk) disable iff (!hresetn)
    mod_en_q == 4'h0 |-> host_int_n;
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt driven with all modules masked");
  property p_ports;
    @(posedge hclk) disable iff (!hresetn)
    av_port_one_is_input == av_port_direction &&
      av_port_two_is_input == !av_port_direction;
  endproperty
  a_ports: assert property (p_ports)
    else $error("av ports not in opposite roles");
  property p_oe;
    @(posedge hclk) disable iff (!hresetn)
    wr_fire && sel_reg(wr_addr_q, lpr_pkg::ADDR_GLOBAL_CTRL) |=>
      av_port_one_oe == $past(hwdata[lpr_pkg::GC_OE1_BIT]) &&
      av_port_two_oe == $past(hwdata[lpr_pkg::GC_OE2_BIT]);
  endproperty
  a_oe: assert property (p_oe)
    else $error("port enables not updated");
  property p_gc_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_fire && sel_reg(wr_addr_q, lpr_pkg::ADDR_GLOBAL_CTRL) |=>
      mod_en_q == $past(hwdata[lpr_pkg::GC_EN_LSB +: 4]) &&
      dir_q == $past(hwdata[lpr_pkg::GC_DIR_BIT]);
  endproperty
  a_gc_write: assert property (p_gc_write)
    else $error("module enables or direction not updated");
  property p_acc_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_fire && sel_reg(wr_addr_q, lpr_pkg::ADDR_PHY_ACCESS) |=>
      tgt_addr_q == $past(hwdata[lpr_pkg::PA_ADDR_LSB +: 4]) &&
      wval_q == $past(hwdata[lpr_pkg::PA_WDATA_LSB +: 8]);
  endproperty
  a_acc_write: assert property (p_acc_write)
    else $error("phy target address or data not stored");
  property p_summary_read;
    @(posedge hclk) disable iff (!hresetn)
    hsel && hready && htrans[1] && !hwrite &&
      sel_reg(haddr, lpr_pkg::ADDR_GLOBAL_CTRL) |=>
      hrdata[3:0] == $past(summary);
  endproperty
  a_summary_read: assert property (p_summary_read)
    else $error("summary bits read back wrong");
  c_read: cover property (@(posedge hclk) disable iff (!hresetn)
    req_fire && !phy_req_write ##[1:50] phy_rx_valid);
  c_write: cover property (@(posedge hclk) disable iff (!hresetn)
    req_fire && phy_req_write);
  c_int: cover property (@(posedge hclk) disable iff (!hresetn)
    !host_int_n);
endmodule
`default_nettype wire

// ---- hw/lpr_pkg.sv ----
/*
  lpr_pkg: shared constants for the link/phy access, interrupt summary and
  timer register bank. Assumes a 32-bit AHB-Lite slave at 250 MHz.
*/
package lpr_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] ADDR_PHY_ACCESS = 12'h014;
  localparam logic [11:0] ADDR_GLOBAL_CTRL = 12'h018;
  localparam logic [11:0] ADDR_TIMER = 12'h01c;
  localparam logic [31:0] RST_PHY_ACCESS = 32'h0000_0000;
  localparam logic [31:0] RST_GLOBAL_CTRL = 32'h0001_0000;
  localparam logic [31:0] RST_TIMER = 32'h0000_0000;
  // ==========================================================
  // field positions
  localparam int PA_RD_BIT = 31;
  localparam int PA_WR_BIT = 30;
  localparam int PA_ADDR_LSB = 24;
  localparam int PA_WDATA_LSB = 16;
  localparam int PA_RXADDR_LSB = 8;
  localparam int GC_EN_LSB = 8;
  localparam int GC_DIR_BIT = 16;
  localparam int GC_OE1_BIT = 17;
  localparam int GC_OE2_BIT = 18;
  localparam int TM_RUN_BIT = 31;
  localparam int TM_CONT_BIT = 30;
  localparam int TM_BRE_BIT = 29;
  localparam int TM_PRELOAD_W = 24;
  // ==========================================================
  // timing: one time unit is two base_clock_25 periods
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TIME_UNIT_PS = 80140;
  // longest time rounds down, at least one cycle
  localparam int UNIT_CYCLES = (TIME_UNIT_PS / CLK_PERIOD_PS) < 1 ? 1 :
                               (TIME_UNIT_PS / CLK_PERIOD_PS);
  localparam int PHY_ZERO_ADDR = 0;
  typedef enum logic [1:0] {LPR_IDLE, LPR_WAIT_ACK} lpr_phy_state_t;
endpackage

// ---- hw/lpr_timer.sv ----
/*
  lpr_timer: 24-bit reloadable down-counter with one-shot, continuous and
  bus-reset-start modes. Assumes bus_reset_start is a one-cycle pulse on
  hclk and that control bits are stable register outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module lpr_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic timer_run,
  input wire logic timer_continuous,
  input wire logic timer_bus_reset_start,
  input wire logic [23:0] preload,
  input wire logic bus_reset_start,
  output logic expired,
  output logic active
);
  localparam int UW = $clog2(lpr_pkg::UNIT_CYCLES + 1);
  logic [23:0] count_q;
  logic [UW-1:0] unit_q;
  logic running_q;
  logic run_prev_q;
  logic start;
  logic stop;
  logic tick;
  logic hit_zero;

  // ==========================================================
  // start and stop decisions
  always_comb begin
    if (timer_bus_reset_start) begin
      start = bus_reset_start;
      stop = 1'b0;
    end else begin
      start = timer_run && !run_prev_q;
      stop = !timer_run;
    end
  end

  assign tick = running_q && (unit_q == UW'(lpr_pkg::UNIT_CYCLES - 1));
  assign hit_zero = tick && (count_q <= 24'h00_0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= timer_run;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running_q <= 1'b0;
      count_q <= 24'h00_0000;
      unit_q <= '0;
    end else if (start) begin
      running_q <= 1'b1;
      count_q <= preload;
      unit_q <= '0;
    end else if (stop) begin
      running_q <= 1'b0;
    end else if (running_q) begin
      unit_q <= tick ? '0 : unit_q + UW'(1);
      if (hit_zero) begin
        // reload regardless of flag acknowledge
        count_q <= preload;
        running_q <= timer_continuous;
      end else if (tick) begin
        count_q <= count_q - 24'h00_0001;
      end
    end
  end

  assign expired = running_q && hit_zero && !start && !stop;
  assign active = running_q;

  // ==========================================================
  // checks
  property p_no_early_expire;
    @(posedge hclk) disable iff (!hresetn)
    start |=> !expired;
  endproperty
  a_no_early_expire: assert property (p_no_early_expire)
    else $error("timer expired right after a start");
  property p_oneshot_stops;
    @(posedge hclk) disable iff (!hresetn)
    expired && !timer_continuous |=> !running_q || start;
  endproperty
  a_oneshot_stops: assert property (p_oneshot_stops)
    else $error("one-shot timer kept running");
  property p_cont_keeps;
    @(posedge hclk) disable iff (!hresetn)
    expired && timer_continuous && !stop |=> running_q;
  endproperty
  a_cont_keeps: assert property (p_cont_keeps)
    else $error("continuous timer stopped");
  property p_cont_reload;
    @(posedge hclk) disable iff (!hresetn)
    expired && timer_continuous |=> count_q == $past(preload);
  endproperty
  a_cont_reload: assert property (p_cont_reload)
    else $error("continuous timer did not reload");
  property p_run_start;
    @(posedge hclk) disable iff (!hresetn)
    !timer_bus_reset_start && timer_run && !run_prev_q |=>
      running_q && count_q == $past(preload);
  endproperty
  a_run_start: assert property (p_run_start)
    else $error("run bit did not start the timer");
  property p_run_stop;
    @(posedge hclk) disable iff (!hresetn)
    !timer_bus_reset_start && !timer_run |=> !running_q;
  endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("cleared run bit did not stop the timer");
  property p_stays_idle;
    @(posedge hclk) disable iff (!hresetn)
    !running_q && !start |=> !running_q;
  endproperty
  a_stays_idle: assert property (p_stays_idle)
    else $error("timer started by itself");
  property p_brs_restart;
    @(posedge hclk) disable iff (!hresetn)
    timer_bus_reset_start && bus_reset_start |=>
      running_q && count_q == $past(preload);
  endproperty
  a_brs_restart: assert property (p_brs_restart)
    else $error("bus reset did not reload the timer");
  property p_brs_ignores_run;
    @(posedge hclk) disable iff (!hresetn)
    timer_bus_reset_start && !bus_reset_start && !running_q |=>
      !running_q;
  endproperty
  a_brs_ignores_run: assert property (p_brs_ignores_run)
    else $error("timer started without a bus reset");
  property p_count_step;
    @(posedge hclk) disable iff (!hresetn)
    tick && !hit_zero && !start && !stop |=>
      count_q == $past(count_q) - 24'h00_0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step down by one");
  property p_unit_step;
    @(posedge hclk) disable iff (!hresetn)
    running_q && !tick && !start && !stop |=>
      unit_q == $past(unit_q) + UW'(1);
  endproperty
  a_unit_step: assert property (p_unit_step)
    else $error("time unit prescaler did not advance");
  c_expire: cover property (@(posedge hclk) disable iff (!hresetn) expired);
endmodule
`default_nettype wire

// ---- verif/lpr_phy_model.sv ----
/*
  lpr_phy_model: behavioural phy on the request/return channel.
  Assumes hclk domain; delay sets both grant and return latency.
*/
`timescale 1ns/1ps
`default_nettype none
module lpr_phy_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] delay,
  input wire logic phy_req_valid,
  output logic phy_req_ready,
  input wire logic phy_req_write,
  input wire logic [3:0] phy_req_addr,
  input wire logic [7:0] phy_req_data,
  output logic phy_rx_valid,
  output logic [3:0] phy_rx_addr,
  output logic [7:0] phy_rx_data
);
  // ==========================================================
  // register file and handshake
  logic [7:0] mem [16];
  logic [3:0] wait_q;
  logic [3:0] ret_q;
  logic pend_q;
  logic [3:0] pa_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++) mem[i] <= 8'h30 + 8'(i);
      {phy_req_ready, phy_rx_valid, pend_q} <= 3'b000;
      {wait_q, ret_q, pa_q, phy_rx_addr} <= 16'h0000;
      phy_rx_data <= 8'h5a;
    end else begin
      phy_req_ready <= 1'b0;
      phy_rx_valid <= 1'b0;
      // idle return lines toggle so a stale value is never mistaken
      phy_rx_addr <= ~phy_rx_addr;
      phy_rx_data <= ~phy_rx_data;
      if (phy_req_valid && phy_req_ready) begin
        wait_q <= 4'h0;
        if (phy_req_write) mem[phy_req_addr] <= phy_req_data;
        else begin
          pend_q <= 1'b1;
          ret_q <= 4'h0;
          pa_q <= phy_req_addr;
        end
      end else if (phy_req_valid) begin
        if (wait_q >= delay) phy_req_ready <= 1'b1;
        else wait_q <= wait_q + 4'h1;
      end
      if (pend_q) begin
        if (ret_q >= delay) begin
          phy_rx_valid <= 1'b1;
          phy_rx_addr <= pa_q;
          phy_rx_data <= mem[pa_q];
          pend_q <= 1'b0;
        end else ret_q <= ret_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/lpr_regs_tb.sv ----
/*
  lpr_regs_tb: self-checking bench for the register bank over AHB-Lite.
  Assumes the designer's 20-cycle time unit and single-slave hready.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module lpr_regs_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, pv, pr, pw, rv, flag, texp, int_n;
  logic [3:0] pa, ra, pend = 4'h0, dly = 4'h0;
  logic [7:0] pd, rdat;
  logic sid = 1'b0, brs = 1'b0, dir, oe1, oe2, in1, in2;
  int fails = 0, check_count = 0, n;
  initial forever #2 hclk = ~hclk;
  lpr_regs u_lpr_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .phy_req_valid(pv),
    .phy_req_ready(pr), .phy_req_write(pw), .phy_req_addr(pa),
    .phy_req_data(pd), .phy_rx_valid(rv), .phy_rx_addr(ra),
    .phy_rx_data(rdat), .self_id_done(sid), .bus_reset_start(brs),
    .linkphy_pending(pend[0]), .iso_rx_pending(pend[1]),
    .iso_tx_pending(pend[2]), .async_pending(pend[3]),
    .timer_int_enable(1'b1), .phy_read_received_flag(flag),
    .timer_expired(texp), .host_int_n(int_n), .av_port_direction(dir),
    .av_port_one_oe(oe1), .av_port_two_oe(oe2),
    .av_port_one_is_input(in1), .av_port_two_is_input(in2));
  lpr_phy_model u_lpr_phy_model (.hclk(hclk), .hresetn(hresetn),
    .delay(dly), .phy_req_valid(pv), .phy_req_ready(pr),
    .phy_req_write(pw), .phy_req_addr(pa), .phy_req_data(pd),
    .phy_rx_valid(rv), .phy_rx_addr(ra), .phy_rx_data(rdat));
  // ==========================================================
  // bus tasks
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // one-cycle pulse on bus_reset_start (1) or self_id_done (0)
  task automatic pulse(input logic to_brs);
    @(posedge hclk);
    if (to_brs) begin
      brs <= 1'b1;
    end else begin
      sid <= 1'b1;
    end
    @(posedge hclk);
    {sid, brs} <= 2'b00;
  endtask
  task automatic wait_flag();
    n = 0;
    while (flag !== 1'b1 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    `CHK("read_flag", 1'b1, flag)
  endtask
  // counts edges until an expiry is seen, or lim edges pass
  task automatic wait_exp(input int lim);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (texp !== 1'b1 && n < lim);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    fails++;
    give_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(lpr_pkg::ADDR_PHY_ACCESS, 1'b0, 0);
    `CHK("acc_rst", lpr_pkg::RST_PHY_ACCESS, q)
    `CHK("okay", 1'b0, hresp)
    bus(lpr_pkg::ADDR_GLOBAL_CTRL, 1'b0, 0);
    `CHK("gc_rst", lpr_pkg::RST_GLOBAL_CTRL, q)
    `CHK("ports_rst", 5'b10010, {dir, oe1, oe2, in1, in2})
    bus(12'h030, 1'b1, 32'hffff_ffff);
    bus(12'h030, 1'b0, 0);
    `CHK("unmapped", 32'h0, q)
    bus(lpr_pkg::ADDR_PHY_ACCESS, 1'b1, 32'h45a5_0000);
    n = 0;
    do begin
      bus(lpr_pkg::ADDR_PHY_ACCESS, 1'b0, 0);
      n++;
    end while (q[30] !== 1'b0 && n < 50);
    `CHK("wr_clear", 1'b0, q[30])
    `CHK("phy_mem", 8'ha5, u_lpr_phy_model.mem[5])
    dly <= 4'd6;
    bus(lpr_pkg::ADDR_PHY_ACCESS, 1'b1, 32'h8500_0000);
    wait_flag();
    bus(lpr_pkg::ADDR_PHY_ACCESS, 1'b0, 0);
    `CHK("rd_fields", 13'h05a5, {q[31], q[11:0]})
    pulse(1'b0);
    wait_flag();
    bus(lpr_pkg::ADDR_PHY_ACCESS, 1'b0, 0);
    `CHK("auto_rd", 12'h030, q[11:0])
    for (int i = 0; i < 4; i++) begin
      pend <= 4'(1 << i);
      bus(lpr_pkg::ADDR_GLOBAL_CTRL, 1'b0, 0);
      `CHK("summary", 4'(1 << i), q[3:0])
      `CHK("int_gated", 1'b1, int_n)
      bus(lpr_pkg::ADDR_GLOBAL_CTRL, 1'b1, 32'h0001_0000 | (32'h100 << i));
      @(posedge hclk);
      `CHK("int_on", 1'b0, int_n)
      pend <= 4'h0;
      @(posedge hclk);
      @(posedge hclk);
      `CHK("int_off", 1'b1, int_n)
      bus(lpr_pkg::ADDR_GLOBAL_CTRL, 1'b0, 0);
      `CHK("auto_clear", 4'h0, q[3:0])
    end
    pend <= 4'h5;
    bus(lpr_pkg::ADDR_GLOBAL_CTRL, 1'b1, 32'h0006_0000);
    bus(lpr_pkg::ADDR_GLOBAL_CTRL, 1'b0, 0);
    `CHK("multi_src", 4'h5, q[3:0])
    `CHK("gc_rw", 12'h006, q[27:16])
    `CHK("ports", 5'b01101, {dir, oe1, oe2, in1, in2})
    `CHK("no_enable", 1'b1, int_n)
    pend <= 4'h0;
    bus(lpr_pkg::ADDR_TIMER, 1'b1, 32'h8000_0003);
    wait_exp(300);
    `CHK("one_shot", 1'b1, n >= 58 && n <= 63)
    wait_exp(200);
    `CHK("stopped", 200, n)
    bus(lpr_pkg::ADDR_TIMER, 1'b0, 0);
    `CHK("preload", 24'h3, q[23:0])
    bus(lpr_pkg::ADDR_TIMER, 1'b1, 32'h0000_0000);
    bus(lpr_pkg::ADDR_TIMER, 1'b1, 32'hc000_0002);
    wait_exp(300);
    wait_exp(300);
    `CHK("reload", 1'b1, n >= 39 && n <= 41)
    bus(lpr_pkg::ADDR_TIMER, 1'b1, 32'h4000_0002);
    wait_exp(200);
    `CHK("run_off", 200, n)
    bus(lpr_pkg::ADDR_TIMER, 1'b1, 32'h2000_0004);
    pulse(1'b1);
    wait_exp(50);
    `CHK("no_early", 50, n)
    pulse(1'b1);
    wait_exp(300);
    `CHK("brs_exp", 1'b1, n >= 78 && n <= 83)
    wait_exp(200);
    `CHK("brs_once", 200, n)
    give_verdict();
  end
endmodule
`default_nettype wire
